//--- hdl/current_input_value_encoder.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    output logic      [AW:0]      level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    // full and empty come from the stored word count
    assign in_ready = (level != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = (level != '0) && (!out_valid || out_ready);

    // storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // registered output word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module current_input_value_encoder #(
    parameter int CHANNELS = encoder_pkg::CHANNELS,
    parameter int DEPTH    = encoder_pkg::FIFO_DEPTH
) (
    input  wire logic                 SYS_CLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire logic                 SAMPLE_VALID_IN,
    input  wire encoder_pkg::sample_t SAMPLE_IN,
    output logic                      SAMPLE_READY_OUT,
    input  wire logic [CHANNELS-1:0]  RANGE_LIVE_ZERO_IN,
    input  wire logic [CHANNELS-1:0]  WIRE_CHECK_EN_IN,
    input  wire logic [CHANNELS-1:0]  HART_ENABLE_IN,
    input  wire logic [CHANNELS-1:0]  HART_ACTIVE_IN,
    output logic                      PROCESS_INPUT_IMAGE_VALID_OUT,
    output encoder_pkg::result_t      PROCESS_INPUT_IMAGE_OUT,
    input  wire logic                 PROCESS_INPUT_IMAGE_READY_IN,
    output logic [CHANNELS-1:0]       CHANNEL_FAULT_INDICATOR_OUT,
    output logic [CHANNELS-1:0]       CHANNEL_HART_ACTIVITY_INDICATOR_OUT,
    output logic                      GROUP_FAULT_INDICATOR_OUT
);
    localparam int AW = $clog2(DEPTH);

    logic                                 rst_meta;
    logic                                 rst_n;
    logic                                 take;
    logic                                 s_valid;
    logic [encoder_pkg::CH_W-1:0]         s_ch;
    logic [encoder_pkg::CUR_W-1:0]        s_cur;
    logic                                 s_live0;
    logic                                 s_wbe;
    logic signed [encoder_pkg::CUR_W:0]   diff;
    logic signed [51:0]                   prod;
    logic signed [19:0]                   scaled;
    logic [encoder_pkg::CUR_W-1:0]        over_lim;
    encoder_pkg::class_t                  cls;
    logic signed [encoder_pkg::CODE_W-1:0] code;
    encoder_pkg::result_t                 push_word;
    logic                                 fifo_in_ready;
    logic [AW:0]                          fifo_level;
    logic                                 is_fault;

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample capture with its channel setup
    assign take = SAMPLE_VALID_IN && SAMPLE_READY_OUT;

    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            s_valid <= 1'b0;
            s_ch    <= '0;
            s_cur   <= '0;
            s_live0 <= 1'b0;
            s_wbe   <= 1'b0;
        end else begin
            s_valid <= take && (SAMPLE_IN.ch < encoder_pkg::CH_W'(CHANNELS));
            s_ch    <= SAMPLE_IN.ch;
            s_cur   <= SAMPLE_IN.current_na;
            if (SAMPLE_IN.ch < encoder_pkg::CH_W'(CHANNELS)) begin
                s_live0 <= RANGE_LIVE_ZERO_IN[SAMPLE_IN.ch];
                s_wbe   <= WIRE_CHECK_EN_IN[SAMPLE_IN.ch];
            end
        end
    end

    // ready only while the fifo has room for all words in flight
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            SAMPLE_READY_OUT <= 1'b0;
        end else begin
            SAMPLE_READY_OUT <= fifo_level <=
                (AW+1)'(DEPTH - encoder_pkg::READY_SLACK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // linear scaling, rounded to nearest step
    always_comb begin
        diff = $signed({1'b0, s_cur});
        if (s_live0) begin
            diff = $signed({1'b0, s_cur}) - $signed({1'b0, encoder_pkg::LIVE_ZERO_NA});
        end
        prod = 52'(diff) * $signed({28'h0, s_live0 ? encoder_pkg::SCALE_4_20
                                                   : encoder_pkg::SCALE_0_20});
        prod   = prod + $signed(encoder_pkg::ROUND_HALF);
        scaled = prod[51:encoder_pkg::FRAC_W];
    end

    // classification, limits checked before the scaled value
    always_comb begin
        over_lim = s_live0 ? encoder_pkg::OVER_LIM_4_20 : encoder_pkg::OVER_LIM_0_20;
        cls  = encoder_pkg::CLS_NOMINAL;
        code = scaled[encoder_pkg::CODE_W-1:0];
        if (s_cur > over_lim) begin
            cls  = encoder_pkg::CLS_OVERFLOW;
            code = encoder_pkg::CODE_OVERFLOW;
        end else if (!s_live0 && s_cur < encoder_pkg::WIRE_LIM_0_20) begin
            cls  = encoder_pkg::CLS_WIRE_BREAK;
            code = encoder_pkg::CODE_WIRE_BRK;
        end else if (s_live0 && s_wbe && s_cur < encoder_pkg::WIRE_LIM_4_20) begin
            cls  = encoder_pkg::CLS_WIRE_BREAK;
            code = encoder_pkg::CODE_WIRE_BRK;
        end else if (s_live0 && !s_wbe && s_cur < encoder_pkg::UNDER_LIM_4_20) begin
            cls  = encoder_pkg::CLS_UNDERFLOW;
            code = encoder_pkg::CODE_UNDERFLOW;
        end else if (scaled > 20'(encoder_pkg::CODE_NOM_MAX)) begin
            cls  = encoder_pkg::CLS_OVERRANGE;
            if (scaled > 20'(encoder_pkg::CODE_OVR_MAX)) begin
                code = encoder_pkg::CODE_OVR_MAX;
            end
        end else if (scaled < 20'(encoder_pkg::CODE_ZERO)) begin
            cls  = encoder_pkg::CLS_UNDERRANGE;
            if (scaled < 20'(encoder_pkg::CODE_UND_MIN)) begin
                code = encoder_pkg::CODE_UND_MIN;
            end
        end
    end

    assign push_word = '{ch: s_ch, cls: cls, code: code};
    assign is_fault  = (cls == encoder_pkg::CLS_OVERFLOW) ||
                       (cls == encoder_pkg::CLS_UNDERFLOW) ||
                       (cls == encoder_pkg::CLS_WIRE_BREAK);

    ////////////////////////////////////////////////////////////////////////////
    // result buffer toward the controller
    stream_fifo #(
        .WIDTH ($bits(encoder_pkg::result_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK_IN),
        .rst_n     (rst_n),
        .in_valid  (s_valid),
        .in_data   (push_word),
        .in_ready  (fifo_in_ready),
        .out_valid (PROCESS_INPUT_IMAGE_VALID_OUT),
        .out_data  (PROCESS_INPUT_IMAGE_OUT),
        .out_ready (PROCESS_INPUT_IMAGE_READY_IN),
        .level     (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // per-channel fault indication, updated on every result
    always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            CHANNEL_FAULT_INDICATOR_OUT <= '0;
            GROUP_FAULT_INDICATOR_OUT   <= 1'b0;
        end else begin
            if (s_valid) begin
                CHANNEL_FAULT_INDICATOR_OUT[s_ch] <= is_fault;
            end
            GROUP_FAULT_INDICATOR_OUT <= |CHANNEL_FAULT_INDICATOR_OUT;
        end
    end

    // hart activity: filtered pin, enable and 4-20 range
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_hart
            logic [2:0] sync;
            logic       steady;
            always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
                if (!rst_n) begin
                    sync   <= 3'h0;
                    steady <= 1'b0;
                end else begin
                    sync <= {sync[1:0], HART_ACTIVE_IN[gi]};
                    if (sync[1] == sync[2]) begin
                        steady <= sync[2];
                    end
                end
            end
            always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
                if (!rst_n) begin
                    CHANNEL_HART_ACTIVITY_INDICATOR_OUT[gi] <= 1'b0;
                end else begin
                    CHANNEL_HART_ACTIVITY_INDICATOR_OUT[gi] <= steady &&
                        HART_ENABLE_IN[gi] && RANGE_LIVE_ZERO_IN[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // checks on the encoding path and the indicators
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!rst_n);

    fifo_never_full_a: assert property (s_valid |-> fifo_in_ready)
        else $error("result pushed into full fifo");
    overflow_code_a: assert property (
        s_valid && s_cur > over_lim |-> code == 16'sh7fff)
        else $error("overflow not coded 7fff");
    wire_zero_a: assert property (
        s_valid && !s_live0 && s_cur < encoder_pkg::WIRE_LIM_0_20
        |-> cls == encoder_pkg::CLS_WIRE_BREAK && code == 16'sh7fff)
        else $error("0-20 wire break missed");
    wire_live_a: assert property (
        s_valid && s_live0 && s_wbe && s_cur < encoder_pkg::WIRE_LIM_4_20
        |-> code == encoder_pkg::CODE_WIRE_BRK && cls != encoder_pkg::CLS_UNDERFLOW)
        else $error("4-20 wire break missed");
    underflow_code_a: assert property (
        s_valid && cls == encoder_pkg::CLS_UNDERFLOW
        |-> s_live0 && !s_wbe && code == 16'sh8000)
        else $error("bad underflow code");
    nominal_span_a: assert property (
        s_valid && cls == encoder_pkg::CLS_NOMINAL |-> code >= 0 && code <= 27648)
        else $error("nominal code outside span");
    overrange_band_a: assert property (
        s_valid && cls == encoder_pkg::CLS_OVERRANGE |-> code >= 27649 && code <= 32511)
        else $error("overrange code outside band");
    underrange_band_a: assert property (
        s_valid && cls == encoder_pkg::CLS_UNDERRANGE
        |-> s_live0 && code <= -1 && code >= -6144)
        else $error("underrange code outside band");
    hart_indicator_a: assert property (
        CHANNEL_HART_ACTIVITY_INDICATOR_OUT[0]
        |-> $past(HART_ENABLE_IN[0] && RANGE_LIVE_ZERO_IN[0] && g_hart[0].steady))
        else $error("hart shown without enable and activity");
    fault_flag_a: assert property (
        s_valid && s_ch == '0 && code == 16'sh7fff |=> CHANNEL_FAULT_INDICATOR_OUT[0])
        else $error("fault indicator not set");
endmodule

//--- hdl/encoder_pkg.sv
package encoder_pkg;
    // channel count and sample widths
    localparam int CHANNELS = 6;
    localparam int CH_W     = 3;
    localparam int CUR_W    = 26;
    localparam int CODE_W   = 16;
    localparam int SCALE_W  = 24;
    localparam int FRAC_W   = 32;
    localparam int FIFO_DEPTH  = 16;
    localparam int READY_SLACK = 4;

    // one code step in nA for each range
    localparam real LSB_NA_0_20 = 723.4;
    localparam real LSB_NA_4_20 = 578.7;
    // fixed-point reciprocal of one step, 32 fraction bits
    localparam logic [SCALE_W-1:0] SCALE_0_20 =
        SCALE_W'(int'(4294967296.0 / LSB_NA_0_20));
    localparam logic [SCALE_W-1:0] SCALE_4_20 =
        SCALE_W'(int'(4294967296.0 / LSB_NA_4_20));
    localparam logic [51:0] ROUND_HALF = 52'h0_0000_8000_0000;

    // current breakpoints in nA
    localparam logic [CUR_W-1:0] LIVE_ZERO_NA    = 26'h03d0900; // 4 mA
    localparam logic [CUR_W-1:0] OVER_LIM_0_20   = 26'h166db30; // 23.518 mA
    localparam logic [CUR_W-1:0] OVER_LIM_4_20   = 26'h15c1d30; // 22.814 mA
    localparam logic [CUR_W-1:0] WIRE_LIM_0_20   = 26'h006c728; // 0.4442 mA
    localparam logic [CUR_W-1:0] WIRE_LIM_4_20   = 26'h036ee80; // 3.6 mA
    localparam logic [CUR_W-1:0] UNDER_LIM_4_20  = 26'h006c7f0; // 0.4444 mA

    // output codes
    localparam logic signed [CODE_W-1:0] CODE_ZERO      = 16'sh0000;
    localparam logic signed [CODE_W-1:0] CODE_NOM_MAX   = 16'sh6c00;
    localparam logic signed [CODE_W-1:0] CODE_OVR_MAX   = 16'sh7eff;
    localparam logic signed [CODE_W-1:0] CODE_OVERFLOW  = 16'sh7fff;
    localparam logic signed [CODE_W-1:0] CODE_WIRE_BRK  = 16'sh7fff;
    localparam logic signed [CODE_W-1:0] CODE_UND_MIN   = 16'she800;
    localparam logic signed [CODE_W-1:0] CODE_UNDERFLOW = 16'sh8000;

    typedef enum logic [2:0] {
        CLS_NOMINAL    = 3'h0,
        CLS_OVERRANGE  = 3'h1,
        CLS_OVERFLOW   = 3'h3,
        CLS_UNDERRANGE = 3'h2,
        CLS_UNDERFLOW  = 3'h6,
        CLS_WIRE_BREAK = 3'h7
    } class_t;

    typedef struct packed {
        logic [CH_W-1:0]  ch;
        logic [CUR_W-1:0] current_na;
    } sample_t;

    typedef struct packed {
        logic [CH_W-1:0]          ch;
        class_t                   cls;
        logic signed [CODE_W-1:0] code;
    } result_t;
endpackage

//--- testbench/controller_model.sv
`timescale 1ns/1ns
// fail-safe controller taking process input words
module controller_model (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 valid_in,
    input  wire encoder_pkg::result_t result_in,
    input  wire logic                 stall_in,
    input  wire logic signed [15:0]   subs_in,
    output logic                      ready_out,
    output encoder_pkg::result_t      last_out,
    output logic signed [15:0]        safe_out,
    output logic [15:0]               count_out
);
    // ready drops while the controller is busy
    assign ready_out = !stall_in;

    // capture each word, fault codes replaced by the substitute
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_out  <= '0;
            safe_out  <= 16'sh0000;
            count_out <= 16'h0000;
        end else if (valid_in && ready_out) begin
            last_out  <= result_in;
            count_out <= count_out + 16'h0001;
            if (result_in.cls inside {encoder_pkg::CLS_OVERFLOW, encoder_pkg::CLS_UNDERFLOW,
                                      encoder_pkg::CLS_WIRE_BREAK}) begin
                safe_out <= subs_in;
            end else begin
                safe_out <= result_in.code;
            end
        end
    end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    typedef struct {int ch; bit live; bit chk; int cur; encoder_pkg::class_t cls;} row_t;
    logic                 clk, rst_n, s_valid, s_ready, p_valid, p_ready, stall, group;
    encoder_pkg::sample_t s_in;
    encoder_pkg::result_t p_out, last;
    logic [5:0]           live, chk_en, h_en, h_act, fault, hart;
    logic signed [15:0]   subs, safe;
    logic [15:0]          count, n;
    int                   fail_count, checks_done, cycles, acc, k;
    bit                   taken;
    row_t rows [13] = '{
        '{0, 0, 0, 10000000, encoder_pkg::CLS_NOMINAL},
        '{1, 0, 0, 22000000, encoder_pkg::CLS_OVERRANGE},
        '{2, 0, 0, 24000000, encoder_pkg::CLS_OVERFLOW},
        '{3, 0, 0, 400000, encoder_pkg::CLS_WIRE_BREAK},
        '{4, 0, 0, 500000, encoder_pkg::CLS_NOMINAL},
        '{5, 1, 0, 12000000, encoder_pkg::CLS_NOMINAL},
        '{0, 1, 0, 2000000, encoder_pkg::CLS_UNDERRANGE},
        '{1, 1, 0, 300000, encoder_pkg::CLS_UNDERFLOW},
        '{2, 1, 1, 3000000, encoder_pkg::CLS_WIRE_BREAK},
        '{3, 1, 1, 300000, encoder_pkg::CLS_WIRE_BREAK},
        '{4, 1, 0, 23000000, encoder_pkg::CLS_OVERFLOW},
        '{5, 1, 1, 3700000, encoder_pkg::CLS_UNDERRANGE},
        '{0, 1, 0, 3999421, encoder_pkg::CLS_UNDERRANGE}};

    current_input_value_encoder current_input_value_encoder_i (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .SAMPLE_VALID_IN(s_valid), .SAMPLE_IN(s_in),
        .SAMPLE_READY_OUT(s_ready), .RANGE_LIVE_ZERO_IN(live), .WIRE_CHECK_EN_IN(chk_en),
        .HART_ENABLE_IN(h_en), .HART_ACTIVE_IN(h_act), .PROCESS_INPUT_IMAGE_VALID_OUT(p_valid),
        .PROCESS_INPUT_IMAGE_OUT(p_out), .PROCESS_INPUT_IMAGE_READY_IN(p_ready),
        .CHANNEL_FAULT_INDICATOR_OUT(fault), .CHANNEL_HART_ACTIVITY_INDICATOR_OUT(hart),
        .GROUP_FAULT_INDICATOR_OUT(group));
    controller_model controller_model_i (
        .clk_in(clk), .rst_n_in(rst_n), .valid_in(p_valid), .result_in(p_out),
        .stall_in(stall), .subs_in(subs), .ready_out(p_ready), .last_out(last),
        .safe_out(safe), .count_out(count));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic signed [15:0] expcode(row_t r);
        real x;
        x = r.live ? (r.cur - 4000000) / encoder_pkg::LSB_NA_4_20
                   : r.cur / encoder_pkg::LSB_NA_0_20;
        if (r.cls == encoder_pkg::CLS_UNDERFLOW) return 16'sh8000;
        if (r.cls inside {encoder_pkg::CLS_OVERFLOW, encoder_pkg::CLS_WIRE_BREAK})
            return 16'sh7fff;
        return 16'($rtoi($floor(x + 0.5)));
    endfunction
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // offer one sample, held until taken
    task send(input int ch, input int cur);
        s_in = '{ch: ch[2:0], current_na: cur[25:0]};
        s_valid = 1'b1;
        while (s_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
        s_valid = 1'b0;
    endtask
    task wait_res(input logic [15:0] want);
        k = 0;
        while (count < want && k < 100) begin
            @(posedge clk) #1;
            k++;
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, s_valid, stall, live, chk_en, h_en, h_act} = '0;
        s_in = '0;
        subs = 16'sh0123;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("ready after release", 0, s_ready);
        // table of encodings
        foreach (rows[i]) begin
            live = {6{rows[i].live}};
            chk_en = {6{rows[i].chk}};
            n = count + 16'h0001;
            send(rows[i].ch, rows[i].cur);
            wait_res(n);
            chk("count", n, count);
            chk("class", rows[i].cls, last.cls);
            chk("code", expcode(rows[i]), last.code);
            chk("channel", rows[i].ch, last.ch);
            chk("safe", rows[i].cls inside {3'h3, 3'h6, 3'h7} ? subs : expcode(rows[i]), safe);
            repeat (3) @(posedge clk) #1;
            chk("fault", rows[i].cls inside {3'h3, 3'h6, 3'h7}, fault[rows[i].ch]);
        end
        chk("group", 1, group);
        // hart indication per range and enable
        live = '1;
        h_en = 6'h21;
        h_act = 6'h21;
        repeat (8) @(posedge clk) #1;
        chk("hart on", 6'h21, hart);
        h_act = 6'h00;
        repeat (8) @(posedge clk) #1;
        chk("hart idle", 6'h00, hart);
        h_act = 6'h21;
        h_en = 6'h00;
        repeat (8) @(posedge clk) #1;
        chk("hart disabled", 6'h00, hart);
        h_en = 6'h21;
        live = '0;
        repeat (8) @(posedge clk) #1;
        chk("hart wrong range", 6'h00, hart);
        // channel beyond six is dropped
        n = count;
        send(6, 10000000);
        repeat (10) @(posedge clk) #1;
        chk("dropped", n, count);
        // fill the fifo with the controller stalled, then drain
        stall = 1'b1;
        s_in = '{ch: 3'h1, current_na: 26'h00f4240};
        s_valid = 1'b1;
        acc = 0;
        repeat (40) begin
            taken = (s_ready === 1'b1);
            @(posedge clk) #1;
            if (taken) acc++;
        end
        s_valid = 1'b0;
        chk("refused", 0, s_ready);
        chk("fill level", 1, acc >= 13 && acc <= 20);
        n = count;
        stall = 1'b0;
        wait_res(n + 16'(acc));
        chk("drained", n + 16'(acc), count);
        chk("empty", 0, p_valid);
        chk("fill code", 16'sh0566, last.code);
        // fault word through the controller, then reset in mid-run
        n = count + 16'h0001;
        send(0, 100000);
        wait_res(n);
        chk("break code", 16'sh7fff, last.code);
        chk("break safe", subs, safe);
        chk("break fault", 1, fault[0]);
        stall = 1'b1;
        send(1, 24000000);
        repeat (5) @(posedge clk) #1;
        chk("held valid", 1, p_valid);
        chk("held code", 16'sh7fff, p_out.code);
        rst_n = 1'b0;
        #1;
        chk("reset valid", 0, p_valid);
        chk("reset fault", 0, {group, fault});
        chk("reset ready", 0, s_ready);
        // second release: the path must work again
        @(posedge clk) #1;
        rst_n = 1'b1;
        stall = 1'b0;
        chk("ready still low", 0, s_ready);
        n = 16'h0001;
        send(2, 10000000);
        wait_res(n);
        chk("count after reset", n, count);
        chk("code after reset", 16'sh3600, last.code);
        results();
    end
endmodule
